//--- src/lmr_exec.sv
// execution unit for or, move, load-literal, load-config, no-op and return
// Functional notes
// - or_literal_into_acc ORs accumulator with 8-bit literal, sets only zero flag.
// - or_acc_with_file_reg ORs accumulator with file register, routes by dest, zero only.
// - destination bit 0 writes accumulator, 1 writes back to file register.
// - store_acc_to_file_reg copies accumulator into file register, flags untouched.
// - move_file_reg copies file register to dest chosen by bit, updates zero.
// - move_file_reg with dest 1 rewrites same value and still sets zero flag.
// - load_literal_into_acc loads literal into accumulator, no flag change.
// - load-config copies accumulator into prescaler/timer config register, flags untouched.
// - return_with_literal loads literal into accumulator, pc from top_of_stack_entry.
// - return_with_literal takes two cycles, discarding the already fetched instruction.
`timescale 1ns/1ps

module lmr_exec #(
    parameter int FILE_REGS = lmr_pkg::FILE_REGS
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       instr_valid,
    input  wire logic [lmr_pkg::INSTR_W-1:0] instr,
    input  wire logic [lmr_pkg::PC_W-1:0]    top_of_stack_entry,
    output logic      [lmr_pkg::DATA_W-1:0]  acc,
    output logic                            zero_flag,
    output logic      [lmr_pkg::DATA_W-1:0]  cfg_reg,
    output logic      [lmr_pkg::PC_W-1:0]    pc,
    output logic                            busy,
    output logic                            stack_pop,
    output logic                            retire,
    output logic                            freg_we,
    output logic      [lmr_pkg::FADDR_W-1:0] freg_addr,
    output logic      [lmr_pkg::DATA_W-1:0]  freg_data
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic lmr_pkg::lmr_op_t lmr_decode(input logic [lmr_pkg::INSTR_W-1:0] iw);
        lmr_pkg::lmr_op_t op;
        op = lmr_pkg::LMR_OP_NOP;
        case (iw[lmr_pkg::OPC_LSB +: 4])
            lmr_pkg::OPC_ORLIT:  op = lmr_pkg::LMR_OP_ORLIT;
            lmr_pkg::OPC_LDLIT:  op = lmr_pkg::LMR_OP_LDLIT;
            lmr_pkg::OPC_RETLIT: op = lmr_pkg::LMR_OP_RETLIT;
            lmr_pkg::OPC_FREG: begin
                case (iw[lmr_pkg::SUB_LSB +: 2])
                    lmr_pkg::SUB_ORF:    op = lmr_pkg::LMR_OP_ORF;
                    lmr_pkg::SUB_MOVE_FILE_REG:   op = lmr_pkg::LMR_OP_MOVE_FILE_REG;
                    lmr_pkg::SUB_STOREF: op = lmr_pkg::LMR_OP_STOREF;
                    default:             op = lmr_pkg::LMR_OP_NOP;
                endcase
            end
            lmr_pkg::OPC_MISC: begin
                if (iw[7:0] == lmr_pkg::MISC_CFG) begin
                    op = lmr_pkg::LMR_OP_CFG;
                end else begin
                    op = lmr_pkg::LMR_OP_NOP;
                end
            end
            default: op = lmr_pkg::LMR_OP_NOP;
        endcase
        return op;
    endfunction : lmr_decode

    typedef enum logic {LMR_ST_RUN, LMR_ST_FLUSH} lmr_state_t;

    lmr_state_t                      state_r;
    logic [lmr_pkg::DATA_W-1:0]      acc_r;
    logic                            zero_r;
    logic [lmr_pkg::DATA_W-1:0]      cfg_r;
    logic [lmr_pkg::PC_W-1:0]        pc_r;
    logic                            pop_r;
    logic                            retire_r;
    logic                            we_r;
    logic [lmr_pkg::FADDR_W-1:0]     waddr_r;
    logic [lmr_pkg::DATA_W-1:0]      wdata_r;
    logic [lmr_pkg::DATA_W-1:0]      freg_r [FILE_REGS];

    lmr_pkg::lmr_op_t                op;
    logic                            take;
    logic                            dest;
    logic [lmr_pkg::FADDR_W-1:0]     faddr;
    logic [lmr_pkg::DATA_W-1:0]      lit;
    logic [lmr_pkg::DATA_W-1:0]      fval;
    logic [lmr_pkg::DATA_W-1:0]      res;
    logic                            res_to_acc;
    logic                            res_to_file;
    logic                            sets_zero;

    assign op    = lmr_decode(instr);
    assign take  = instr_valid && (state_r == LMR_ST_RUN);
    assign dest  = instr[lmr_pkg::DEST_BIT];
    assign faddr = instr[lmr_pkg::FADDR_LSB +: lmr_pkg::FADDR_W];
    assign lit   = instr[lmr_pkg::LIT_LSB +: lmr_pkg::DATA_W];
    assign fval  = freg_r[faddr];

    // ------------------------------------------------------------
    // result and routing
    // ------------------------------------------------------------
    always_comb begin
        res         = acc_r;
        res_to_acc  = 1'b0;
        res_to_file = 1'b0;
        sets_zero   = 1'b0;
        case (op)
            lmr_pkg::LMR_OP_ORLIT: begin
                res        = acc_r | lit;
                res_to_acc = 1'b1;
                sets_zero  = 1'b1;
            end
            lmr_pkg::LMR_OP_ORF: begin
                res         = acc_r | fval;
                res_to_acc  = (dest == lmr_pkg::DEST_ACC);
                res_to_file = (dest == lmr_pkg::DEST_FILE);
                sets_zero   = 1'b1;
            end
            lmr_pkg::LMR_OP_MOVE_FILE_REG: begin
                res         = fval;
                res_to_acc  = (dest == lmr_pkg::DEST_ACC);
                res_to_file = (dest == lmr_pkg::DEST_FILE);
                sets_zero   = 1'b1;
            end
            lmr_pkg::LMR_OP_STOREF: begin
                res         = acc_r;
                res_to_file = 1'b1;
            end
            lmr_pkg::LMR_OP_LDLIT: begin
                res        = lit;
                res_to_acc = 1'b1;
            end
            lmr_pkg::LMR_OP_RETLIT: begin
                res        = lit;
                res_to_acc = 1'b1;
            end
            default: begin
                res = acc_r;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // second cycle discards fetched word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= LMR_ST_RUN;
        end else begin
            case (state_r)
                LMR_ST_RUN: begin
                    if (take && op == lmr_pkg::LMR_OP_RETLIT) begin
                        state_r <= LMR_ST_FLUSH;
                    end
                end
                LMR_ST_FLUSH: state_r <= LMR_ST_RUN;
                default:      state_r <= LMR_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_r <= lmr_pkg::PC_RST;
        end else if (take) begin
            if (op == lmr_pkg::LMR_OP_RETLIT) begin
                pc_r <= top_of_stack_entry;
            end else begin
                pc_r <= pc_r + 11'h001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pop_r    <= 1'b0;
            retire_r <= 1'b0;
        end else begin
            pop_r    <= take && (op == lmr_pkg::LMR_OP_RETLIT);
            retire_r <= (take && op != lmr_pkg::LMR_OP_RETLIT) || (state_r == LMR_ST_FLUSH);
        end
    end

    // ------------------------------------------------------------
    // accumulator, zero flag, config register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= lmr_pkg::ACC_RST;
        end else if (take && res_to_acc) begin
            acc_r <= res;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zero_r <= 1'b0;
        end else if (take && sets_zero) begin
            zero_r <= (res == 8'h00);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_r <= lmr_pkg::CFG_RST;
        end else if (take && op == lmr_pkg::LMR_OP_CFG) begin
            cfg_r <= acc_r;
        end
    end

    // ------------------------------------------------------------
    // file registers
    // ------------------------------------------------------------
    for (genvar g = 0; g < FILE_REGS; g++) begin : g_freg
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                freg_r[g] <= lmr_pkg::FREG_RST;
            end else if (take && res_to_file && faddr == (lmr_pkg::FADDR_W)'(g)) begin
                freg_r[g] <= res;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            we_r    <= 1'b0;
            waddr_r <= '0;
            wdata_r <= 8'h00;
        end else begin
            we_r <= take && res_to_file;
            if (take && res_to_file) begin
                waddr_r <= faddr;
                wdata_r <= res;
            end
        end
    end

    assign acc       = acc_r;
    assign zero_flag = zero_r;
    assign cfg_reg   = cfg_r;
    assign pc        = pc_r;
    assign busy      = (state_r == LMR_ST_FLUSH);
    assign stack_pop = pop_r;
    assign retire    = retire_r;
    assign freg_we   = we_r;
    assign freg_addr = waddr_r;
    assign freg_data = wdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    orlit_result_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_ORLIT |=> acc_r == ($past(acc_r) | $past(lit))
            && zero_r == (($past(acc_r) | $past(lit)) == 8'h00))
        else $error("or literal result wrong");

    orf_result_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_ORF && dest == lmr_pkg::DEST_ACC
            |=> acc_r == ($past(acc_r) | $past(fval)) && !we_r)
        else $error("or file result to accumulator wrong");

    dest_file_a: assert property (@(posedge clk) disable iff (rst)
        take && (op == lmr_pkg::LMR_OP_ORF || op == lmr_pkg::LMR_OP_MOVE_FILE_REG)
            && dest == lmr_pkg::DEST_FILE
            |=> we_r && waddr_r == $past(faddr) && $stable(acc_r))
        else $error("file destination not written");

    store_acc_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_STOREF
            |=> we_r && wdata_r == $past(acc_r) && $stable(zero_r)
            ##1 freg_r[waddr_r] == wdata_r || we_r)
        else $error("store accumulator wrong");

    move_file_reg_zero_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_MOVE_FILE_REG && dest == lmr_pkg::DEST_ACC
            |=> acc_r == $past(fval) && zero_r == ($past(fval) == 8'h00))
        else $error("move file to accumulator wrong");

    move_file_reg_test_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_MOVE_FILE_REG && dest == lmr_pkg::DEST_FILE
            |=> wdata_r == $past(fval) && zero_r == ($past(fval) == 8'h00))
        else $error("move file test wrong");

    ldlit_flags_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_LDLIT |=> acc_r == $past(lit) && $stable(zero_r))
        else $error("load literal wrong");

    cfg_load_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_CFG
            |=> cfg_r == $past(acc_r) && $stable(zero_r) && $stable(acc_r))
        else $error("config load wrong");

    ret_load_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_RETLIT
            |=> pc_r == $past(top_of_stack_entry) && acc_r == $past(lit)
            && $stable(zero_r) && pop_r)
        else $error("return load wrong");

    ret_two_cycle_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_RETLIT
            |=> busy && !retire_r ##1 !busy && retire_r && $stable(pc_r) && $stable(acc_r))
        else $error("return not two cycles");

    nop_quiet_a: assert property (@(posedge clk) disable iff (rst)
        take && op == lmr_pkg::LMR_OP_NOP
            |=> pc_r == $past(pc_r) + 11'h001 && $stable(acc_r) && $stable(zero_r)
            && $stable(cfg_r) && !we_r && !busy && retire_r)
        else $error("no-op changed state");

    one_cycle_a: assert property (@(posedge clk) disable iff (rst)
        take && op != lmr_pkg::LMR_OP_RETLIT |=> retire_r && !busy)
        else $error("single-cycle instruction stalled");

endmodule : lmr_exec

//--- src/lmr_pkg.sv
// constants, encodings and types for the logic/move/return execution unit
package lmr_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int INSTR_W   = 12;
    localparam int DATA_W    = 8;
    localparam int FADDR_W   = 5;
    localparam int PC_W      = 11;
    localparam int FILE_REGS = 32;

    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int OPC_LSB   = 8;
    localparam int SUB_LSB   = 6;
    localparam int DEST_BIT  = 5;
    localparam int FADDR_LSB = 0;
    localparam int LIT_LSB   = 0;

    // ------------------------------------------------------------
    // operation codes in instr[11:8]
    // ------------------------------------------------------------
    localparam logic [3:0] OPC_MISC   = 4'h0;
    localparam logic [3:0] OPC_ORLIT  = 4'h1;
    localparam logic [3:0] OPC_LDLIT  = 4'h2;
    localparam logic [3:0] OPC_RETLIT = 4'h3;
    localparam logic [3:0] OPC_FREG   = 4'h4;

    // sub codes in instr[7:6] under OPC_FREG
    localparam logic [1:0] SUB_ORF    = 2'h0;
    localparam logic [1:0] SUB_MOVE_FILE_REG   = 2'h1;
    localparam logic [1:0] SUB_STOREF = 2'h2;

    // low byte codes under OPC_MISC
    localparam logic [7:0] MISC_NOP   = 8'h00;
    localparam logic [7:0] MISC_CFG   = 8'h01;

    // destination bit values
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [7:0]  CFG_RST  = 8'hFF;
    localparam logic [7:0]  FREG_RST = 8'h00;
    localparam logic [10:0] PC_RST   = 11'h7FF;

    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    localparam int RET_CYCLES = 2;
    localparam int ONE_CYCLES = 1;

    typedef enum logic [2:0] {
        LMR_OP_NOP,
        LMR_OP_CFG,
        LMR_OP_ORLIT,
        LMR_OP_LDLIT,
        LMR_OP_RETLIT,
        LMR_OP_ORF,
        LMR_OP_MOVE_FILE_REG,
        LMR_OP_STOREF
    } lmr_op_t;

endpackage : lmr_pkg

//--- bench/tb.sv
// self-checking testbench for the logic/move/return execution unit
`timescale 1ns/1ps

module tb;
    // ------------------------------------------------------------
    // design signals and bench state
    // ------------------------------------------------------------
    logic                        clk;
    logic                        rst;
    logic                        instr_valid;
    logic [lmr_pkg::INSTR_W-1:0] instr;
    logic [lmr_pkg::PC_W-1:0]    top_of_stack_entry;
    logic [lmr_pkg::DATA_W-1:0]  acc;
    logic                        zero_flag;
    logic [lmr_pkg::DATA_W-1:0]  cfg_reg;
    logic [lmr_pkg::PC_W-1:0]    pc;
    logic                        busy;
    logic                        stack_pop;
    logic                        retire;
    logic                        freg_we;
    logic [lmr_pkg::FADDR_W-1:0] freg_addr;
    logic [lmr_pkg::DATA_W-1:0]  freg_data;
    logic [lmr_pkg::PC_W-1:0]    pc_m;
    int                          fails;
    int                          n_checks;

    lmr_exec uut (
        .clk                (clk),
        .rst                (rst),
        .instr_valid        (instr_valid),
        .instr              (instr),
        .top_of_stack_entry (top_of_stack_entry),
        .acc                (acc),
        .zero_flag          (zero_flag),
        .cfg_reg            (cfg_reg),
        .pc                 (pc),
        .busy               (busy),
        .stack_pop          (stack_pop),
        .retire             (retire),
        .freg_we            (freg_we),
        .freg_addr          (freg_addr),
        .freg_data          (freg_data)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    function automatic logic [11:0] fword(logic [1:0] sub, logic d, logic [4:0] f);
        return {lmr_pkg::OPC_FREG, sub, d, f};
    endfunction : fword

    // valid stays high so instructions run back to back
    task automatic exec(input logic [11:0] ins);
        instr_valid = 1'b1;
        instr = ins;
        @(posedge clk);
        #1;
        pc_m = pc_m + 11'h001;
        check(retire, 1'b1);
        check(pc, pc_m);
        check(busy, 1'b0);
    endtask : exec

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(acc, lmr_pkg::ACC_RST);
        check(cfg_reg, lmr_pkg::CFG_RST);
        check(pc, lmr_pkg::PC_RST);
        check({busy, stack_pop, retire, freg_we, zero_flag}, 5'h00);
    endtask : t_reset

    task automatic t_ldlit();
        logic [23:0] lits = 24'hFF005A;
        exec({lmr_pkg::OPC_ORLIT, 8'h00});
        check(zero_flag, 1'b1);
        for (int i = 0; i < 3; i++) begin
            exec({lmr_pkg::OPC_LDLIT, lits[23-8*i -: 8]});
            check(acc, lits[23-8*i -: 8]);
            check(zero_flag, 1'b1);
        end
    endtask : t_ldlit

    task automatic t_orlit();
        exec({lmr_pkg::OPC_LDLIT, 8'h0F});
        exec({lmr_pkg::OPC_ORLIT, 8'hF0});
        check(acc, 8'hFF);
        check(zero_flag, 1'b0);
        exec({lmr_pkg::OPC_LDLIT, 8'h00});
        exec({lmr_pkg::OPC_ORLIT, 8'h00});
        check(acc, 8'h00);
        check(zero_flag, 1'b1);
        check(freg_we, 1'b0);
    endtask : t_orlit

    task automatic t_store();
        exec({lmr_pkg::OPC_LDLIT, 8'hA5});
        exec(fword(lmr_pkg::SUB_STOREF, 1'b0, 5'h1F));
        check({freg_we, freg_addr, freg_data}, {1'b1, 5'h1F, 8'hA5});
        check(zero_flag, 1'b1);
        exec({lmr_pkg::OPC_LDLIT, 8'h00});
        check(freg_we, 1'b0);
        exec(fword(lmr_pkg::SUB_STOREF, 1'b0, 5'h00));
        check({freg_we, freg_addr, freg_data}, {1'b1, 5'h00, 8'h00});
    endtask : t_store

    task automatic t_move_file_reg();
        exec(fword(lmr_pkg::SUB_MOVE_FILE_REG, 1'b0, 5'h1F));
        check({acc, zero_flag, freg_we}, {8'hA5, 1'b0, 1'b0});
        exec(fword(lmr_pkg::SUB_MOVE_FILE_REG, 1'b1, 5'h00));
        check({freg_we, freg_addr, freg_data}, {1'b1, 5'h00, 8'h00});
        check({acc, zero_flag}, {8'hA5, 1'b1});
    endtask : t_move_file_reg

    task automatic t_orf();
        exec({lmr_pkg::OPC_LDLIT, 8'h0A});
        exec(fword(lmr_pkg::SUB_ORF, 1'b1, 5'h1F));
        check({freg_we, freg_addr, freg_data}, {1'b1, 5'h1F, 8'hAF});
        check({acc, zero_flag}, {8'h0A, 1'b0});
        exec(fword(lmr_pkg::SUB_MOVE_FILE_REG, 1'b0, 5'h1F));
        check(acc, 8'hAF);
        exec(fword(lmr_pkg::SUB_MOVE_FILE_REG, 1'b1, 5'h1F));
        check({freg_we, freg_addr, freg_data}, {1'b1, 5'h1F, 8'hAF});
        check({acc, zero_flag}, {8'hAF, 1'b0});
        exec({lmr_pkg::OPC_LDLIT, 8'h00});
        exec(fword(lmr_pkg::SUB_ORF, 1'b0, 5'h00));
        check({acc, zero_flag, freg_we}, {8'h00, 1'b1, 1'b0});
    endtask : t_orf

    task automatic t_cfg();
        exec({lmr_pkg::OPC_LDLIT, 8'h3C});
        exec({lmr_pkg::OPC_MISC, lmr_pkg::MISC_CFG});
        check({cfg_reg, acc, zero_flag}, {8'h3C, 8'h3C, 1'b1});
    endtask : t_cfg

    task automatic t_nop();
        exec({lmr_pkg::OPC_MISC, lmr_pkg::MISC_NOP});
        check({acc, cfg_reg, zero_flag, freg_we, stack_pop}, {16'h3C3C, 3'h4});
        exec(fword(2'h3, 1'b0, 5'h05));
        check({acc, cfg_reg, zero_flag, freg_we, stack_pop}, {16'h3C3C, 3'h4});
    endtask : t_nop

    // return, then an instruction offered in the discard cycle is ignored
    task automatic t_ret();
        top_of_stack_entry = 11'h123;
        instr_valid = 1'b1;
        instr = {lmr_pkg::OPC_RETLIT, 8'h9C};
        @(posedge clk);
        #1;
        check({acc, zero_flag, stack_pop}, {8'h9C, 1'b1, 1'b1});
        check(pc, 11'h123);
        check({busy, retire}, 2'h2);
        instr = {lmr_pkg::OPC_LDLIT, 8'hEE};
        top_of_stack_entry = 11'h456;
        @(posedge clk);
        #1;
        check({busy, retire, stack_pop}, 3'h2);
        check({acc, pc}, {8'h9C, 11'h123});
        pc_m = 11'h123;
        exec({lmr_pkg::OPC_LDLIT, 8'h77});
        check(acc, 8'h77);
        instr_valid = 1'b0;
        @(posedge clk);
        #1;
        check({retire, pc}, {1'b0, pc_m});
    endtask : t_ret

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        fails = 0;
        n_checks = 0;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = 12'h000;
        top_of_stack_entry = 11'h000;
        pc_m = lmr_pkg::PC_RST;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_ldlit();
        t_orlit();
        t_store();
        t_move_file_reg();
        t_orf();
        t_cfg();
        t_nop();
        t_ret();
        final_report();
    end

    initial begin
        #20000;
        fails++;
        final_report();
    end
endmodule : tb
